/* File: rtl/scr_config_regs.sv */
// Link mode and serial bus control registers with watchdog and CRC counter
`timescale 1ns/1ps
module scr_config_regs #(
  parameter int WD_LONG_CYC  = scr_pkg::SCR_WD_LONG_CYC,
  parameter int WD_SHORT_CYC = scr_pkg::SCR_WD_SHORT_CYC
) (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_remote_i,
  input  wire logic        reg_rd_i,
  output logic      [7:0]  reg_rdata_o,
  input  wire logic        crc_error_i,
  input  wire logic        strap_compat_i,
  input  wire logic        strap_low_freq_i,
  input  wire logic        des_unprotected_i,
  input  wire logic        active_video_flag_i,
  input  wire logic [23:0] pixel_data_i,
  output logic      [23:0] pixel_data_o,
  output logic             failsafe_low_o,
  output logic             legacy_compat_mode_o,
  output logic             low_freq_range_select_o,
  output logic      [5:0]  sda_delay_cycles_o,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             scl_o,
  output logic             scl_oe_o,
  output logic             bus_free_o
);
  logic [7:0]  cfg_q, cfg_d, ctl_q, ctl_d, rdata_q, rdata_d;
  logic [15:0] crc_q, crc_d;
  logic [23:0] pix_q, pix_d;
  logic        bc_q, bc_d, lf_q, lf_d;
  logic [5:0]  dly_q, dly_d;
  logic [1:0]  strap_bc_s, strap_lf_s, scl_s, sda_s;
  logic        wr_ok, gate;
  logic        wd_free, wd_oe;

  function automatic logic [5:0] sda_cycles(input logic [1:0] code);
    sda_cycles = 6'(scr_pkg::SCR_SDA_BASE_CYC + scr_pkg::SCR_SDA_STEP_CYC * int'(code));
  endfunction : sda_cycles

  // Pins from outside the clock domain, two flops each
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      strap_bc_s <= '0;
      strap_lf_s <= '0;
      scl_s      <= 2'h3;
      sda_s      <= 2'h3;
    end
    else
    begin
      strap_bc_s <= {strap_bc_s[0], strap_compat_i};
      strap_lf_s <= {strap_lf_s[0], strap_low_freq_i};
      scl_s      <= {scl_s[0], scl_i};
      sda_s      <= {sda_s[0], sda_i};
    end
  end

  always_comb
  begin
    // R09 remote writes rejected when disabled
    // R10 only register writes are gated here
    wr_ok = reg_wr_i && !(reg_remote_i && ctl_q[scr_pkg::SCR_CTL_LWD]);
    cfg_d = cfg_q;
    ctl_d = ctl_q;
    // R16 reserved bits masked on write
    if (wr_ok && reg_addr_i == scr_pkg::SCR_ADDR_CFG)
      cfg_d = reg_wdata_i & scr_pkg::SCR_CFG_WMASK;
    if (wr_ok && reg_addr_i == scr_pkg::SCR_ADDR_CTL)
      ctl_d = reg_wdata_i & scr_pkg::SCR_CTL_WMASK;
    // R02 held clear while bit set
    // R15 sixteen-bit error count
    if (cfg_q[scr_pkg::SCR_CFG_CRC_CLR])
      crc_d = '0;
    else if (crc_error_i && crc_q != 16'hffff)
      crc_d = crc_q + 16'h0001;
    else
      crc_d = crc_q;
    // R04 legacy mode source
    // R05 register legacy enable
    bc_d = cfg_q[scr_pkg::SCR_CFG_BC_SRC] ? cfg_q[scr_pkg::SCR_CFG_BC] : strap_bc_s[1];
    // R06 frequency range source
    // R07 register low range select
    lf_d = cfg_q[scr_pkg::SCR_CFG_LF_SRC] ? cfg_q[scr_pkg::SCR_CFG_LF] : strap_lf_s[1];
    // R03 gate pixels with active video
    gate  = cfg_q[scr_pkg::SCR_CFG_GATE] && bc_q && des_unprotected_i;
    pix_d = (gate && !active_video_flag_i) ? 24'h000000 : pixel_data_i;
    // R08 delay in clock cycles
    dly_d = sda_cycles(ctl_q[scr_pkg::SCR_CTL_DLY_HI:scr_pkg::SCR_CTL_DLY_LO]);
    rdata_d = rdata_q;
    if (reg_rd_i)
    begin
      unique case (reg_addr_i)
        scr_pkg::SCR_ADDR_CFG:    rdata_d = cfg_q;
        scr_pkg::SCR_ADDR_CTL:    rdata_d = ctl_q;
        scr_pkg::SCR_ADDR_CRC_LO: rdata_d = crc_q[7:0];
        scr_pkg::SCR_ADDR_CRC_HI: rdata_d = crc_q[15:8];
        default:                  rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cfg_q   <= scr_pkg::SCR_CFG_RESET;
      ctl_q   <= scr_pkg::SCR_CTL_RESET;
      crc_q   <= '0;
      bc_q    <= 1'b0;
      lf_q    <= 1'b0;
      pix_q   <= '0;
      dly_q   <= 6'(scr_pkg::SCR_SDA_BASE_CYC);
      rdata_q <= '0;
    end
    else
    begin
      cfg_q   <= cfg_d;
      ctl_q   <= ctl_d;
      crc_q   <= crc_d;
      bc_q    <= bc_d;
      lf_q    <= lf_d;
      pix_q   <= pix_d;
      dly_q   <= dly_d;
      rdata_q <= rdata_d;
    end
  end

  // R11 timeout choice
  // R12 disable bit
  scr_watchdog #(
    .LONG_CYC  (WD_LONG_CYC),
    .SHORT_CYC (WD_SHORT_CYC),
    .HALF_CYC  (scr_pkg::SCR_SCL_HALF_CYC)
  ) u_watchdog (
    .clk_sys_i    (clk_sys_i),
    .rst_i        (rst_i),
    .scl_s_i      (scl_s[1]),
    .sda_s_i      (sda_s[1]),
    .disable_i    (ctl_q[scr_pkg::SCR_CTL_WD_DIS]),
    .speedup_i    (ctl_q[scr_pkg::SCR_CTL_SPEEDUP]),
    .bus_free_o   (wd_free),
    .scl_oe_o     (wd_oe),
    .recovering_o ()
  );

  // Open drain: only ever pulls low
  assign scl_o                   = 1'b0;
  assign scl_oe_o                = wd_oe;
  assign bus_free_o              = wd_free;
  assign reg_rdata_o             = rdata_q;
  assign pixel_data_o            = pix_q;
  // R01 failsafe level
  assign failsafe_low_o          = cfg_q[scr_pkg::SCR_CFG_FAILSAFE];
  assign legacy_compat_mode_o    = bc_q;
  assign low_freq_range_select_o = lf_q;
  assign sda_delay_cycles_o      = dly_q;

  property p_failsafe_write;
    @(posedge clk_sys_i) disable iff (rst_i)
    (reg_wr_i && !reg_remote_i && reg_addr_i == scr_pkg::SCR_ADDR_CFG)
      |=> failsafe_low_o == $past(reg_wdata_i[7]);
  endproperty
  a_failsafe_write: assert property (p_failsafe_write) else $error("failsafe bit not written"); // R01

  property p_crc_held_clear;
    @(posedge clk_sys_i) disable iff (rst_i)
    cfg_q[scr_pkg::SCR_CFG_CRC_CLR] |=> crc_q == 16'h0000;
  endproperty
  a_crc_held_clear: assert property (p_crc_held_clear) else $error("CRC count not cleared"); // R02

  property p_gate_blank;
    @(posedge clk_sys_i) disable iff (rst_i)
    (cfg_q[4] && bc_q && des_unprotected_i && !active_video_flag_i) |=> pixel_data_o == 24'h0;
  endproperty
  a_gate_blank: assert property (p_gate_blank) else $error("pixel data not gated"); // R03

  property p_pass_ungated;
    @(posedge clk_sys_i) disable iff (rst_i)
    !cfg_q[4] |=> pixel_data_o == $past(pixel_data_i);
  endproperty
  a_pass_ungated: assert property (p_pass_ungated) else $error("pixel data blocked"); // R03

  property p_bc_source;
    @(posedge clk_sys_i) disable iff (rst_i)
    ##1 legacy_compat_mode_o == ($past(cfg_q[3]) ? $past(cfg_q[2]) : $past(strap_bc_s[1]));
  endproperty
  a_bc_source: assert property (p_bc_source) else $error("legacy mode source wrong"); // R04

  property p_lf_source;
    @(posedge clk_sys_i) disable iff (rst_i)
    ##1 low_freq_range_select_o == ($past(cfg_q[1]) ? $past(cfg_q[0]) : $past(strap_lf_s[1]));
  endproperty
  a_lf_source: assert property (p_lf_source) else $error("frequency range source wrong"); // R06

  property p_sda_delay;
    @(posedge clk_sys_i) disable iff (rst_i)
    ##1 sda_delay_cycles_o == 6'd30 + 6'd5 * 6'($past(ctl_q[4:3]));
  endproperty
  a_sda_delay: assert property (p_sda_delay) else $error("SDA delay count wrong"); // R08

  property p_remote_reject;
    @(posedge clk_sys_i) disable iff (rst_i)
    (reg_wr_i && reg_remote_i && ctl_q[2]) |=> $stable(cfg_q) && $stable(ctl_q);
  endproperty
  a_remote_reject: assert property (p_remote_reject) else $error("remote write accepted"); // R09

  property p_reserved_zero;
    @(posedge clk_sys_i) disable iff (rst_i)
    (reg_rd_i && reg_addr_i == scr_pkg::SCR_ADDR_CTL) |=> reg_rdata_o[7:5] == 3'h0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits nonzero"); // R16
endmodule : scr_config_regs

/* File: rtl/scr_pkg.sv */
// Constants, register map and timing for the serializer configuration registers
// Notes on behaviour
// R01: Config bit 7 picks failsafe level: one pulls idle inputs low, zero high.
// R02: While config bit 5 is one, CRC error counters stay cleared; software clears it.
// R03: Config bit 4 gates pixel data with active video flag in legacy unprotected mode.
// R04: Config bit 3 picks legacy mode source: register bit 2 or strap pin.
// R05: With bit 3 set, bit 2 enables legacy compatibility mode; default off.
// R06: Config bit 1 picks frequency range source: register bit 0 or strap pin.
// R07: With bit 1 set, bit 0 selects 5 to 15 MHz range; default 15-85 MHz.
// R08: Control bits 4:3 set SDA delay 240 ns plus 40 ns per step.
// R09: Control bit 2 rejects local register writes arriving over the control channel.
// R10: Local write disable never blocks remote access to slaves behind the serializer.
// R11: Control bit 1 sets watchdog timeout: one about 50 ms, zero about 1 s.
// R12: Control bit 0 disables the bus watchdog; clear lets it run.
// R13: Running watchdog marks bus free after SDA high and idle for the timeout.
// R14: SDA stuck low and idle until timeout makes the device drive nine SCL pulses.
// R15: Back-channel CRC error count reads as 16 bits over low and high bytes.
// R16: Reserved bits of both registers read zero; writes to them are ignored.
package scr_pkg;
  localparam logic [7:0] SCR_ADDR_CFG     = 8'h04;
  localparam logic [7:0] SCR_ADDR_CTL     = 8'h05;
  localparam logic [7:0] SCR_ADDR_CRC_LO  = 8'h0a;
  localparam logic [7:0] SCR_ADDR_CRC_HI  = 8'h0b;
  localparam logic [7:0] SCR_CFG_RESET    = 8'h80;
  localparam logic [7:0] SCR_CTL_RESET    = 8'h00;
  localparam logic [7:0] SCR_CFG_WMASK    = 8'hbf;
  localparam logic [7:0] SCR_CTL_WMASK    = 8'h1f;
  localparam int         SCR_CFG_FAILSAFE = 7;
  localparam int         SCR_CFG_CRC_CLR  = 5;
  localparam int         SCR_CFG_GATE     = 4;
  localparam int         SCR_CFG_BC_SRC   = 3;
  localparam int         SCR_CFG_BC       = 2;
  localparam int         SCR_CFG_LF_SRC   = 1;
  localparam int         SCR_CFG_LF       = 0;
  localparam int         SCR_CTL_DLY_HI   = 4;
  localparam int         SCR_CTL_DLY_LO   = 3;
  localparam int         SCR_CTL_LWD      = 2;
  localparam int         SCR_CTL_SPEEDUP  = 1;
  localparam int         SCR_CTL_WD_DIS   = 0;
  localparam int         SCR_CLK_PERIOD_NS = 8;
  localparam int         SCR_CLK_KHZ       = 125000;
  localparam int         SCR_SDA_BASE_NS   = 240;
  localparam int         SCR_SDA_STEP_NS   = 40;
  localparam int         SCR_SDA_BASE_CYC  =
    (SCR_SDA_BASE_NS + SCR_CLK_PERIOD_NS - 1) / SCR_CLK_PERIOD_NS;
  localparam int         SCR_SDA_STEP_CYC  =
    (SCR_SDA_STEP_NS + SCR_CLK_PERIOD_NS - 1) / SCR_CLK_PERIOD_NS;
  localparam int         SCR_WD_LONG_MS    = 1000;
  localparam int         SCR_WD_SHORT_MS   = 50;
  localparam int         SCR_WD_LONG_CYC   = SCR_WD_LONG_MS * SCR_CLK_KHZ;
  localparam int         SCR_WD_SHORT_CYC  = SCR_WD_SHORT_MS * SCR_CLK_KHZ;
  localparam int         SCR_SCL_HALF_NS   = 5000;
  localparam int         SCR_SCL_HALF_CYC  = SCR_SCL_HALF_NS / SCR_CLK_PERIOD_NS;
  localparam logic [3:0] SCR_RECOVER_PULSES = 4'h9;
  localparam int         SCR_WD_CNT_W      = 27;

  typedef enum logic [1:0] {
    SCR_WD_WATCH   = 2'b01,
    SCR_WD_RECOVER = 2'b10
  } scr_wd_state_t;
endpackage : scr_pkg

/* File: rtl/scr_watchdog.sv */
// Serial bus watchdog with hung-bus recovery pulses
`timescale 1ns/1ps
module scr_watchdog #(
  parameter int LONG_CYC  = scr_pkg::SCR_WD_LONG_CYC,
  parameter int SHORT_CYC = scr_pkg::SCR_WD_SHORT_CYC,
  parameter int HALF_CYC  = scr_pkg::SCR_SCL_HALF_CYC
) (
  input  wire logic clk_sys_i,
  input  wire logic rst_i,
  input  wire logic scl_s_i,
  input  wire logic sda_s_i,
  input  wire logic disable_i,
  input  wire logic speedup_i,
  output logic      bus_free_o,
  output logic      scl_oe_o,
  output logic      recovering_o
);
  localparam int W = scr_pkg::SCR_WD_CNT_W;
  localparam logic [W-1:0] LONG_LIM  = W'(LONG_CYC - 1);
  localparam logic [W-1:0] SHORT_LIM = W'(SHORT_CYC - 1);
  localparam logic [W-1:0] HALF_LIM  = W'(HALF_CYC - 1);

  scr_pkg::scr_wd_state_t st_q, st_d;
  logic [W-1:0] cnt_q, cnt_d;
  logic [3:0]   pulses_q, pulses_d;
  logic         scl_p_q, scl_p_d, sda_p_q, sda_p_d;
  logic         free_q, free_d, oe_q, oe_d;
  logic         activity;
  logic [W-1:0] limit;

  always_comb
  begin
    activity = (scl_s_i != scl_p_q) || (sda_s_i != sda_p_q);
    // R11 timeout select
    limit    = speedup_i ? SHORT_LIM : LONG_LIM;
    st_d     = st_q;
    cnt_d    = cnt_q;
    pulses_d = pulses_q;
    free_d   = free_q;
    oe_d     = oe_q;
    scl_p_d  = scl_s_i;
    sda_p_d  = sda_s_i;
    unique case (st_q)
      scr_pkg::SCR_WD_WATCH:
      begin
        oe_d = 1'b0;
        // R12 watchdog disable
        if (disable_i || activity)
        begin
          cnt_d  = '0;
          free_d = 1'b0;
        end
        else if (cnt_q >= limit)
        begin
          cnt_d = '0;
          // R13 idle high means free
          if (sda_s_i)
            free_d = 1'b1;
          // R14 start recovery clocks
          else
          begin
            st_d     = scr_pkg::SCR_WD_RECOVER;
            pulses_d = '0;
            oe_d     = 1'b1;
          end
        end
        else
          cnt_d = cnt_q + 1'b1;
      end
      scr_pkg::SCR_WD_RECOVER:
      begin
        // R14 nine pulses, low then released
        if (cnt_q >= HALF_LIM)
        begin
          cnt_d = '0;
          oe_d  = ~oe_q;
          if (oe_q)
          begin
            pulses_d = pulses_q + 1'b1;
            if (pulses_q + 1'b1 == scr_pkg::SCR_RECOVER_PULSES)
              st_d = scr_pkg::SCR_WD_WATCH;
          end
        end
        else
          cnt_d = cnt_q + 1'b1;
      end
      default:
      begin
        st_d  = scr_pkg::SCR_WD_WATCH;
        cnt_d = '0;
        oe_d  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st_q     <= scr_pkg::SCR_WD_WATCH;
      cnt_q    <= '0;
      pulses_q <= '0;
      free_q   <= 1'b0;
      oe_q     <= 1'b0;
      scl_p_q  <= 1'b1;
      sda_p_q  <= 1'b1;
    end
    else
    begin
      st_q     <= st_d;
      cnt_q    <= cnt_d;
      pulses_q <= pulses_d;
      free_q   <= free_d;
      oe_q     <= oe_d;
      scl_p_q  <= scl_p_d;
      sda_p_q  <= sda_p_d;
    end
  end

  assign bus_free_o   = free_q;
  assign scl_oe_o     = oe_q;
  assign recovering_o = (st_q == scr_pkg::SCR_WD_RECOVER);

  property p_wd_disabled;
    @(posedge clk_sys_i) disable iff (rst_i)
    (disable_i && st_q == scr_pkg::SCR_WD_WATCH) |=> !free_q && !oe_q;
  endproperty
  a_wd_disabled: assert property (p_wd_disabled) else $error("watchdog acted while disabled"); // R12

  property p_free_needs_high;
    @(posedge clk_sys_i) disable iff (rst_i)
    $rose(free_q) |-> $past(sda_s_i) && $past(cnt_q) >= $past(limit);
  endproperty
  a_free_needs_high: assert property (p_free_needs_high) else $error("bus free without idle high"); // R13

  property p_recover_on_low;
    @(posedge clk_sys_i) disable iff (rst_i)
    $rose(oe_q) && $past(st_q) == scr_pkg::SCR_WD_WATCH |-> !$past(sda_s_i);
  endproperty
  a_recover_on_low: assert property (p_recover_on_low) else $error("recovery without SDA low"); // R14

  property p_nine_pulses;
    @(posedge clk_sys_i) disable iff (rst_i)
    $fell(st_q == scr_pkg::SCR_WD_RECOVER) |-> pulses_q == scr_pkg::SCR_RECOVER_PULSES;
  endproperty
  a_nine_pulses: assert property (p_nine_pulses) else $error("recovery pulse count wrong"); // R14
endmodule : scr_watchdog

/* File: tb/scr_bus_model.sv */
// Far side of the serial bus: pull-ups, a host and a slave that can hang SDA
`timescale 1ns/1ps
module scr_bus_model (
  input  wire logic clk_sys_i,
  input  wire logic rst_i,
  input  wire logic dut_scl_oe_i,
  input  wire logic host_scl_low_i,
  input  wire logic hang_i,
  output logic      scl_o,
  output logic      sda_o
);
  logic       hung_q;
  logic       hung_d;
  logic       scl_q;
  logic [3:0] seen_q;
  logic [3:0] seen_d;
  // Open drain with pull-ups, so a released line reads high
  assign scl_o = ~(dut_scl_oe_i | host_scl_low_i);
  assign sda_o = ~hung_q;
  // hung slave waits for nine clocks
  always_comb
  begin
    hung_d = hung_q | hang_i;
    seen_d = hang_i ? 4'h0 : seen_q;
    if (hung_q && scl_o && !scl_q)
    begin
      seen_d = seen_q + 4'h1;
      hung_d = (seen_q != 4'h8);
    end
  end
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      hung_q <= 1'b0;
      seen_q <= 4'h0;
      scl_q  <= 1'b1;
    end
    else
    begin
      hung_q <= hung_d;
      seen_q <= seen_d;
      scl_q  <= scl_o;
    end
  end
endmodule : scr_bus_model

/* File: tb/test_serializer_config_i2c_control_regs.sv */
// Self-checking bench for the link mode and bus control registers
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin failures++; \
  $display("Error %s expected %h got %h", nm, e, g); end end
module test_serializer_config_i2c_control_regs;
  localparam int LONG  = 200;
  localparam int SHORT = 50;
  logic        clk_sys_i, rst_i, reg_wr_i, reg_remote_i, reg_rd_i, crc_error_i;
  logic        strap_compat_i, strap_low_freq_i, des_unprotected_i, active_video_flag_i;
  logic [7:0]  reg_addr_i, reg_wdata_i, reg_rdata_o;
  logic [23:0] pixel_data_i, pixel_data_o;
  logic        failsafe_low_o, legacy_compat_mode_o, low_freq_range_select_o;
  logic [5:0]  sda_delay_cycles_o;
  logic        scl_w, sda_w, scl_oe_o, bus_free_o, host_scl_low, hang, oe_prev;
  logic        scl_drv;
  logic [7:0]  sel;
  logic [23:0] pix_exp;
  int          failures, checked, seed, cfg, ctl, crc, k, n;

  scr_config_regs #(
    .WD_LONG_CYC  (LONG),
    .WD_SHORT_CYC (SHORT)
  ) dut (
    .clk_sys_i               (clk_sys_i),
    .rst_i                   (rst_i),
    .reg_addr_i              (reg_addr_i),
    .reg_wdata_i             (reg_wdata_i),
    .reg_wr_i                (reg_wr_i),
    .reg_remote_i            (reg_remote_i),
    .reg_rd_i                (reg_rd_i),
    .reg_rdata_o             (reg_rdata_o),
    .crc_error_i             (crc_error_i),
    .strap_compat_i          (strap_compat_i),
    .strap_low_freq_i        (strap_low_freq_i),
    .des_unprotected_i       (des_unprotected_i),
    .active_video_flag_i     (active_video_flag_i),
    .pixel_data_i            (pixel_data_i),
    .pixel_data_o            (pixel_data_o),
    .failsafe_low_o          (failsafe_low_o),
    .legacy_compat_mode_o    (legacy_compat_mode_o),
    .low_freq_range_select_o (low_freq_range_select_o),
    .sda_delay_cycles_o      (sda_delay_cycles_o),
    .scl_i                   (scl_w),
    .sda_i                   (sda_w),
    .scl_o                   (scl_drv),
    .scl_oe_o                (scl_oe_o),
    .bus_free_o              (bus_free_o)
  );
  scr_bus_model bus (
    .clk_sys_i      (clk_sys_i),
    .rst_i          (rst_i),
    .dut_scl_oe_i   (scl_oe_o),
    .host_scl_low_i (host_scl_low),
    .hang_i         (hang),
    .scl_o          (scl_w),
    .sda_o          (sda_w)
  );

  initial
  begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end

  task automatic give_verdict();
    if (failures == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : give_verdict

  function automatic logic legacy_exp();
    return cfg[3] ? cfg[2] : strap_compat_i;
  endfunction : legacy_exp

  task automatic put(input logic [7:0] a, input logic [7:0] d, input logic rem);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    reg_remote_i <= rem;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
    reg_remote_i <= 1'b0;
    if (!(rem && ctl[2]) && a == 8'h04) cfg = d & 8'hbf;
    if (!(rem && ctl[2]) && a == 8'h05) ctl = d & 8'h1f;
    if (cfg[5]) crc = 0;
  endtask : put

  task automatic chk_reg(input logic [7:0] a);
    logic [7:0] e;
    e = (a == 8'h04) ? cfg : (a == 8'h05) ? ctl : (a == 8'h0a) ? crc[7:0] :
        (a == 8'h0b) ? crc[15:8] : 8'h00;
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    #1;
    `CHK("rdata", e, reg_rdata_o)
  endtask : chk_reg

  task automatic chk_out();
    repeat (4) @(posedge clk_sys_i);
    #1;
    `CHK("failsafe", cfg[7], failsafe_low_o)
    `CHK("legacy", legacy_exp(), legacy_compat_mode_o)
    `CHK("lowfreq", cfg[1] ? cfg[0] : strap_low_freq_i, low_freq_range_select_o)
    `CHK("sdadly", 6'((240 + 40 * ctl[4:3]) / 8), sda_delay_cycles_o)
  endtask : chk_out

  task automatic errs(input int m);
    repeat (m) @(posedge clk_sys_i) crc_error_i <= 1'b1;
    @(posedge clk_sys_i) crc_error_i <= 1'b0;
    if (!cfg[5]) crc = crc + m;
  endtask : errs

  // Bus activity, then idle until judged free within the timeout window
  task automatic idle_free(input int t);
    int c;
    @(posedge clk_sys_i) host_scl_low <= 1'b1;
    repeat (6) @(posedge clk_sys_i);
    #1;
    `CHK("busy", 1'b0, bus_free_o)
    @(posedge clk_sys_i) host_scl_low <= 1'b0;
    #1;
    // Look just after each edge so the flag is settled
    for (c = 0; c < t + 20 && bus_free_o !== 1'b1; c++)
    begin
      @(posedge clk_sys_i);
      #1;
    end
    `CHK("free", 1'b1, bus_free_o && c >= t && c <= t + 10)
    if (c >= t + 20) give_verdict();
  endtask : idle_free

  initial
  begin
    seed = 19421;
    {failures, checked, ctl, crc} = '0;
    cfg = 'h80;
    {reg_wr_i, reg_rd_i, reg_remote_i, crc_error_i, host_scl_low, hang} = '0;
    {strap_compat_i, strap_low_freq_i, des_unprotected_i, active_video_flag_i} = '0;
    {reg_addr_i, reg_wdata_i, pixel_data_i} = '0;
    rst_i = 1'b1;
    repeat (2) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    chk_reg(8'h04);
    chk_reg(8'h05);
    chk_out();
    for (k = 0; k < 24; k++)
    begin
      @(posedge clk_sys_i);
      strap_compat_i <= 1'($random(seed));
      strap_low_freq_i <= 1'($random(seed));
      put(k[0] ? 8'h05 : 8'h04, 8'($random(seed)), k[2]);
      chk_reg(8'h04);
      chk_reg(8'h05);
      chk_out();
    end
    // Lock, then far-side writes must bounce while local ones land
    put(8'h05, 8'h04, 1'b0);
    put(8'h04, 8'h55, 1'b1);
    put(8'h05, 8'h00, 1'b1);
    chk_reg(8'h04);
    chk_reg(8'h05);
    put(8'h04, 8'h55, 1'b0);
    chk_reg(8'h04);
    put(8'h07, 8'hff, 1'b0);
    put(8'h0a, 8'h55, 1'b0);
    chk_reg(8'h07);
    chk_reg(8'h0a);
    put(8'h04, 8'h00, 1'b0);
    errs(256 + {$random(seed)} % 64);
    chk_reg(8'h0a);
    chk_reg(8'h0b);
    put(8'h04, 8'h20, 1'b0);
    errs(5);
    chk_reg(8'h0a);
    chk_reg(8'h0b);
    put(8'h04, 8'h00, 1'b0);
    errs(3);
    chk_reg(8'h0a);
    for (k = 0; k < 48; k++)
    begin
      // Alternate gate on and off; one pass forces legacy mode by register
      sel = (k[3] ? 8'h00 : 8'h10) | (k[4] ? 8'h0c : 8'h00);
      if (k % 8 == 0) put(8'h04, sel | (8'($random(seed)) & 8'h0f), 1'b0);
      @(posedge clk_sys_i);
      pixel_data_i <= 24'($random(seed));
      des_unprotected_i <= 1'($random(seed));
      active_video_flag_i <= 1'($random(seed));
      @(posedge clk_sys_i);
      #1;
      pix_exp = (cfg[4] && legacy_exp() && des_unprotected_i && !active_video_flag_i) ?
                24'h0 : pixel_data_i;
      `CHK("pixel", pix_exp, pixel_data_o)
    end
    put(8'h05, 8'h02, 1'b0);
    idle_free(SHORT);
    put(8'h05, 8'h00, 1'b0);
    idle_free(LONG);
    put(8'h05, 8'h01, 1'b0);
    @(posedge clk_sys_i) host_scl_low <= 1'b1;
    @(posedge clk_sys_i) host_scl_low <= 1'b0;
    repeat (LONG + 50) @(posedge clk_sys_i);
    #1;
    `CHK("wd_off", 1'b0, bus_free_o)
    put(8'h05, 8'h02, 1'b0);
    @(posedge clk_sys_i) hang <= 1'b1;
    @(posedge clk_sys_i) hang <= 1'b0;
    n = 0;
    oe_prev = 1'b0;
    repeat (9 * 1250 + 4 * SHORT)
    begin
      @(posedge clk_sys_i);
      #1;
      if (scl_oe_o === 1'b1 && oe_prev !== 1'b1) n++;
      oe_prev = scl_oe_o;
    end
    `CHK("pulses", 9, n)
    `CHK("scl_o", 1'b0, scl_drv)
    `CHK("freed", 1'b1, bus_free_o)
    give_verdict();
  end
endmodule : test_serializer_config_i2c_control_regs
